// *** bench/adc_scan_buffer_sequencer_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_scan_buffer_sequencer_bench;
    import asb_pkg::*;
    typedef struct {
        logic [31:0] ctrl;
        logic [31:0] mux;
        logic [15:0] scan;
        int          n_irq;
        logic [11:0] addr;
        logic [31:0] exp;
        logic        half;
    } asb_row_t;
    logic           clock_in;
    logic           rst_in;
    asb_apb_req_t   apb_q;
    asb_apb_rsp_t   apb_out;
    asb_conv_req_t  conv;
    logic           done;
    logic [15:0]    res;
    logic           irq_out;
    logic [31:0]    rd;
    logic           er;
    int             n_mismatch = 0;
    int             check_count = 0;
    asb_row_t rows[5] = '{
        '{32'h0000_0004, 32'h8985_0000, 16'h0000, 1, 12'h040, 32'h0000_0005, 1'b0},
        '{32'h0000_047C, 32'h0000_0000, 16'hFFFF, 1, 12'h07C, 32'h0000_001F, 1'b1},
        '{32'h0000_0416, 32'h0000_0000, 16'h0007, 1, 12'h048, 32'h0000_0012, 1'b1},
        '{32'h0000_0416, 32'h0000_0000, 16'h0007, 2, 12'h060, 32'h0000_0010, 1'b0},
        '{32'h0000_0414, 32'h0000_0000, 16'h0007, 2, 12'h04C, 32'h0000_0013, 1'b0}
    };
    asb_sequencer dut_u (.clock_in(clock_in), .rst_in(rst_in), .apb_in(apb_q),
        .apb_out(apb_out), .conv_out(conv), .conv_done_in(done), .conv_result_in(res),
        .irq_out(irq_out));
    asb_conv_model conv_u (.clock_in(clock_in), .req_in(conv), .done_out(done), .res_out(res));
    // ======
    // Tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_in);
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock_in);
        apb_q.penable <= 1'b1;
        for (k = 0; k < 20 && apb_out.pready !== 1'b1; k++) @(posedge clock_in);
        rd = apb_out.prdata;
        er = apb_out.pslverr;
        apb_q <= '0;
        if (k == 20) begin
            n_mismatch++;
            test_done();
        end
    endtask
    // Bounded: a stuck sequencer ends the run
    task automatic wait_irq();
        int k;
        for (k = 0; k < 3000 && irq_out !== 1'b1; k++) @(posedge clock_in);
        if (k == 3000) begin
            n_mismatch++;
            test_done();
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // ======
    // Sequence
    initial begin
        rst_in = 1'b1;
        apb_q = '0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, irq_out}, 32'h0000_0000);
        $display("reset test done");
        apb(1'b1, 12'h010, 32'h0000_0001);
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, 32'h0000_0000);
            apb(1'b1, 12'h004, rows[i].mux);
            apb(1'b1, 12'h008, {16'h0000, rows[i].scan});
            apb(1'b0, 12'h00C, 32'h0000_0000);
            apb(1'b1, 12'h000, rows[i].ctrl);
            repeat (rows[i].n_irq) begin
                wait_irq();
                apb(1'b0, 12'h00C, 32'h0000_0000);
            end
            apb(1'b0, rows[i].addr, 32'h0000_0000);
            check(rd, rows[i].exp);
            apb(1'b0, 12'h000, 32'h0000_0000);
            check({31'h0, rd[7]}, {31'h0, rows[i].half});
            $display("row %0d done", i);
        end
        apb(1'b0, 12'h020, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 12'h040, 32'h0000_0000);
        check({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        repeat (40) @(posedge clock_in);
        check({31'h0, irq_out}, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_0001);
        wait_irq();
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b0, 12'h014, 32'h0000_0000);
        check({31'h0, rd[0]}, 32'h0000_0001);
        apb(1'b1, 12'h014, 32'h0000_0001);
        apb(1'b0, 12'h014, 32'h0000_0000);
        check({31'h0, rd[0]}, 32'h0000_0000);
        $display("hand tests done");
        test_done();
    end
endmodule
`default_nettype wire

// *** bench/asb_conv_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module asb_conv_model (
    // Clock
    input  wire logic                   clock_in,
    // Converter side
    input  wire asb_pkg::asb_conv_req_t req_in,
    output var  logic                   done_out,
    output var  logic [15:0]            res_out
);
    import asb_pkg::*;
    logic [15:0] val;
    // ======
    // Delay varies by channel: prompt and slow answers
    initial begin
        done_out = 1'b0;
        res_out = 16'h5A5A;
        forever begin
            @(posedge clock_in);
            if (req_in.start) begin
                val = {11'h000, req_in.neg_is_ref, req_in.pos_ch};
                repeat (1 + 3 * req_in.pos_ch[1:0]) @(posedge clock_in);
                done_out <= 1'b1;
                res_out <= val;
                @(posedge clock_in);
                done_out <= 1'b0;
                res_out <= ~val;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/asb_sequencer_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module asb_sequencer_chk (
    // Watched ports
    input wire logic                   clock_in,
    input wire logic                   rst_in,
    input wire asb_pkg::asb_apb_req_t  apb_in,
    input wire asb_pkg::asb_apb_rsp_t  apb_out,
    input wire asb_pkg::asb_conv_req_t conv_out,
    input wire logic                   conv_done_in,
    input wire logic [15:0]            conv_result_in,
    input wire logic                   irq_out
);
    import asb_pkg::*;
    logic [31:0] ctrl_q;
    logic [31:0] mux_q;
    logic [15:0] scan_q;
    logic [3:0]  last_q;
    logic        seen_q;
    logic        wr;
    logic        st;
    assign wr = apb_in.psel & apb_in.penable & apb_in.pwrite & apb_out.pready;
    assign st = conv_out.start & ctrl_q[2];
    // ======
    // Shadow of the written settings, the last started channel and a start-seen bit
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_q <= '0;
            mux_q <= '0;
            scan_q <= '0;
            seen_q <= 1'b0;
            last_q <= '0;
        end else begin
            if (wr && apb_in.paddr == 12'h000) ctrl_q <= apb_in.pwdata;
            if (wr && apb_in.paddr == 12'h004) mux_q <= apb_in.pwdata;
            if (wr && apb_in.paddr == 12'h008) scan_q <= apb_in.pwdata[15:0];
            if (conv_out.start) last_q <= conv_out.pos_ch;
            seen_q <= (wr && apb_in.paddr == 12'h000) ? 1'b0 : (seen_q | conv_out.start);
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_rdy; apb_out.pready |=> !apb_out.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready longer than one cycle");
    property p_err; apb_out.pslverr |-> apb_out.pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_pulse; conv_out.start |=> !conv_out.start; endproperty
    a_pulse: assert property (p_pulse) else $error("start not a pulse");
    property p_gap; conv_done_in && ctrl_q[2] && !apb_in.psel |-> ##2 conv_out.start; endproperty
    a_gap: assert property (p_gap) else $error("next start late");
    property p_muxa; st && !ctrl_q[0] && !ctrl_q[10] |-> conv_out.pos_ch == mux_q[19:16];
    endproperty
    a_muxa: assert property (p_muxa) else $error("wrong mux A channel");
    property p_neg; st && !ctrl_q[0] |-> conv_out.neg_is_ref == !mux_q[23]; endproperty
    a_neg: assert property (p_neg) else $error("wrong negative input");
    property p_list; st && ctrl_q[10] && scan_q != 0 |-> scan_q[conv_out.pos_ch]; endproperty
    a_list: assert property (p_list) else $error("channel not listed");
    property p_asc; st && ctrl_q[10] && &scan_q && seen_q |-> conv_out.pos_ch == last_q + 4'h1;
    endproperty
    a_asc: assert property (p_asc) else $error("scan not ascending");
    property p_irq; $fell(irq_out) |-> apb_in.penable; endproperty
    a_irq: assert property (p_irq) else $error("irq dropped by itself");
endmodule
bind asb_sequencer asb_sequencer_chk chk_u (.clock_in(clock_in), .rst_in(rst_in),
    .apb_in(apb_in), .apb_out(apb_out), .conv_out(conv_out), .conv_done_in(conv_done_in),
    .conv_result_in(conv_result_in), .irq_out(irq_out));
`default_nettype wire

// *** core/asb_sequencer.sv ***
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "asb_consts.svh"
// Behaviour
// (RULE1) Sixteen-sample code raises interrupt only after the sixteenth result.
// (RULE2) Split bit clear: one sixteen-word buffer filled from slot zero.
// (RULE3) Alternate bit clear: every sample uses mux A selection.
// (RULE4) Mux A negative bit clear selects negative reference for mux A.
// (RULE5) Scan enable takes mux A positive input from the scan bitmap.
// (RULE6) Scan listed inputs ascending, each result to next slot, repeat.
// (RULE7) Single buffer: pointer returns to slot zero after each interrupt.
// (RULE8) Split bit set: two eight-word halves filled on alternate interrupts.
// (RULE9) Split bit changes nothing else in selection, scan or counting.
// (RULE10) Dual mode: first sequence from slot 0, next from slot 8, alternating.
// (RULE11) Fill-half status bit toggles after every interrupt.
// (RULE12) Three-sample code raises interrupt after every third sample.
// (RULE13) Software sets scanned inputs analog in pin configuration first.
// (RULE14) Interrupt flag set at each point, held until software clears it.

module asb_sequencer (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    // APB slave
    input  wire asb_pkg::asb_apb_req_t apb_in,
    output var  asb_pkg::asb_apb_rsp_t apb_out,
    // Converter core
    output var  asb_pkg::asb_conv_req_t conv_out,
    input  wire logic                  conv_done_in,
    input  wire logic [15:0]           conv_result_in,
    // Interrupt
    output var  logic                  irq_out
);
    import asb_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        asb_state_t     st;
        logic [31:0]    ctrl;
        logic [31:0]    mux;
        logic [15:0]    scan_list;
        logic [1:0]     status;
        logic [1:0]     mask;
        logic           flag;
        logic [3:0]     wptr;
        logic [3:0]     smp_cnt;
        logic [3:0]     scan_pos;
        logic           alt_b;
        logic           fill_half_status;
        logic [15:0][15:0] buf_mem;
        asb_apb_rsp_t   apb;
        asb_conv_req_t  conv;
        logic           irq;
    } asb_state_all_t;

    asb_state_all_t s_q;
    asb_state_all_t s_d;

    // Next listed channel at or above a start point, wrapping
    function automatic logic [3:0] next_scan(input logic [15:0] list,
                                             input logic [3:0]  from);
        logic [3:0] idx;
        next_scan = from;
        for (int i = 15; i >= 0; i--) begin
            idx = 4'(from + 4'(i));
            if (list[idx]) begin
                next_scan = idx;
            end
        end
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    logic       apb_acc;
    logic       apb_wr;
    logic       apb_rd;
    logic       sample_evt;
    logic       seq_evt;
    logic [3:0] samples_per_irq;
    logic       res_hit;
    logic [3:0] res_idx;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        apb_acc    = apb_in.psel && apb_in.penable && !s_q.apb.pready;
        apb_wr     = apb_acc && apb_in.pwrite;
        apb_rd     = apb_acc && !apb_in.pwrite;
        samples_per_irq       = s_q.ctrl[`ASB_CTRL_SAMPLES_PER_IRQ_HI:`ASB_CTRL_SAMPLES_PER_IRQ_LO];
        sample_evt = 1'b0;
        seq_evt    = 1'b0;
        res_hit    = (apb_in.paddr >= `ASB_OFF_RES_BASE) &&
                     (apb_in.paddr <= `ASB_OFF_RES_TOP) && (apb_in.paddr[1:0] == 2'b00);
        res_idx    = apb_in.paddr[5:2];

        s_d.conv.start = 1'b0;
        s_d.apb.pready = 1'b0;
        s_d.apb.pslverr = 1'b0;
        s_d.apb.prdata = 32'h0000_0000;

        // Conversion sequencing
        case (s_q.st)
            ASB_IDLE: begin
                if (s_q.ctrl[`ASB_CTRL_ENABLE]) begin
                    s_d.st = ASB_REQ;
                end
            end
            ASB_REQ: begin
                s_d.conv.start = 1'b1;
                if (s_q.ctrl[`ASB_CTRL_ALTERNATE_INPUT_SEL] && s_q.alt_b) begin
                    s_d.conv.pos_ch     = s_q.mux[`ASB_MUX_BPOS_HI:`ASB_MUX_BPOS_LO];
                    s_d.conv.neg_is_ref = !s_q.mux[`ASB_MUX_BNEG];
                end else begin
                    // Mux A whenever alternation is off
                    s_d.conv.neg_is_ref = !s_q.mux[`ASB_MUX_ANEG]; // (RULE3) (RULE4)
                    if (s_q.ctrl[`ASB_CTRL_SCAN]) begin
                        s_d.conv.pos_ch = next_scan(s_q.scan_list, s_q.scan_pos); // (RULE5)
                    end else begin
                        s_d.conv.pos_ch = s_q.mux[`ASB_MUX_APOS_HI:`ASB_MUX_APOS_LO];
                    end
                end
                s_d.conv.neg_ch = 4'h1;
                s_d.st = ASB_WAIT;
            end
            ASB_WAIT: begin
                if (conv_done_in) begin
                    // Drop a late result after disable: it would skew the rearmed sequence
                    sample_evt = s_q.ctrl[`ASB_CTRL_ENABLE];
                    s_d.st = s_q.ctrl[`ASB_CTRL_ENABLE] ? ASB_REQ : ASB_IDLE;
                end
            end
            default: s_d.st = ASB_IDLE;
        endcase

        if (sample_evt) begin
            // Next slot; split bit only affects addressing
            s_d.buf_mem[s_q.wptr] = conv_result_in; // (RULE6) (RULE9)
            s_d.wptr = 4'(s_q.wptr + 4'h1); // (RULE2)
            if (!(s_q.ctrl[`ASB_CTRL_ALTERNATE_INPUT_SEL] && s_q.alt_b) && s_q.ctrl[`ASB_CTRL_SCAN]) begin
                s_d.scan_pos = 4'(s_d.conv.pos_ch + 4'h1); // (RULE6)
            end
            s_d.alt_b = s_q.ctrl[`ASB_CTRL_ALTERNATE_INPUT_SEL] ? !s_q.alt_b : 1'b0;
            // Count n+1 samples for code n: 0010 gives 3, 1111 gives 16
            if (s_q.smp_cnt >= samples_per_irq) begin // (RULE1) (RULE12)
                seq_evt = 1'b1;
                s_d.smp_cnt = 4'h0;
            end else begin
                s_d.smp_cnt = 4'(s_q.smp_cnt + 4'h1);
            end
        end

        if (seq_evt) begin
            s_d.fill_half_status = !s_q.fill_half_status; // (RULE11)
            if (s_q.ctrl[`ASB_CTRL_BUFFER_SPLIT_MODE]) begin
                s_d.wptr = s_q.fill_half_status ? `ASB_SLOT_ZERO : `ASB_HALF_BASE; // (RULE8) (RULE10)
            end else begin
                s_d.wptr = `ASB_SLOT_ZERO; // (RULE7)
            end
        end

        // APB writes
        if (apb_wr) begin
            if (hit(apb_in.paddr, `ASB_OFF_CTRL)) begin
                s_d.ctrl = apb_in.pwdata;
                s_d.ctrl[`ASB_CTRL_FILL_HALF_STATUS] = 1'b0;
                if (!apb_in.pwdata[`ASB_CTRL_ENABLE]) begin
                    // Disabling rearms the sequence at slot zero
                    s_d.wptr = `ASB_SLOT_ZERO;
                    s_d.smp_cnt = 4'h0;
                    s_d.fill_half_status = 1'b0;
                    s_d.scan_pos = 4'h0;
                    s_d.alt_b = 1'b0;
                end
            end else if (hit(apb_in.paddr, `ASB_OFF_MUX)) begin
                s_d.mux = apb_in.pwdata;
            end else if (hit(apb_in.paddr, `ASB_OFF_SCAN)) begin
                s_d.scan_list = apb_in.pwdata[15:0];
            end else if (hit(apb_in.paddr, `ASB_OFF_MASK)) begin
                s_d.mask = apb_in.pwdata[1:0];
            end else if (hit(apb_in.paddr, `ASB_OFF_FLAG)) begin
                if (apb_in.pwdata[0]) begin
                    s_d.flag = 1'b0;
                end
            end else if (!hit(apb_in.paddr, `ASB_OFF_STATUS) && !res_hit) begin
                s_d.apb.pslverr = 1'b1;
            end else if (res_hit) begin
                s_d.apb.pslverr = 1'b1;
            end
        end

        // APB reads
        if (apb_rd) begin
            if (hit(apb_in.paddr, `ASB_OFF_CTRL)) begin
                s_d.apb.prdata = s_q.ctrl;
                s_d.apb.prdata[`ASB_CTRL_FILL_HALF_STATUS] = s_q.fill_half_status; // (RULE11)
            end else if (hit(apb_in.paddr, `ASB_OFF_MUX)) begin
                s_d.apb.prdata = s_q.mux;
            end else if (hit(apb_in.paddr, `ASB_OFF_SCAN)) begin
                s_d.apb.prdata = {16'h0000, s_q.scan_list};
            end else if (hit(apb_in.paddr, `ASB_OFF_STATUS)) begin
                s_d.apb.prdata = {30'h0000_0000, s_q.status};
                s_d.status = 2'b00;
            end else if (hit(apb_in.paddr, `ASB_OFF_MASK)) begin
                s_d.apb.prdata = {30'h0000_0000, s_q.mask};
            end else if (hit(apb_in.paddr, `ASB_OFF_FLAG)) begin
                s_d.apb.prdata = {31'h0000_0000, s_q.flag};
            end else if (res_hit) begin
                // Results stay readable until overwritten
                s_d.apb.prdata = {16'h0000, s_q.buf_mem[res_idx]}; // (RULE14)
            end else begin
                s_d.apb.pslverr = 1'b1;
            end
        end
        if (apb_acc) begin
            s_d.apb.pready = 1'b1;
        end

        // Set wins over clear
        if (seq_evt) begin
            s_d.flag = 1'b1; // (RULE14)
            s_d.status[`ASB_ST_SEQ] = 1'b1;
        end
        if (sample_evt) begin
            s_d.status[`ASB_ST_SAMPLE] = 1'b1;
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_out  = s_q.apb;
    assign conv_out = s_q.conv;
    assign irq_out  = s_q.irq;

endmodule
`default_nettype wire

// *** shared/asb_consts.svh ***
`ifndef ASB_CONSTS_SVH
`define ASB_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define ASB_OFF_CTRL     12'h000
`define ASB_OFF_MUX      12'h004
`define ASB_OFF_SCAN     12'h008
`define ASB_OFF_STATUS   12'h00C
`define ASB_OFF_MASK     12'h010
`define ASB_OFF_FLAG     12'h014
`define ASB_OFF_RES_BASE 12'h040
`define ASB_OFF_RES_TOP  12'h07C

// ==========================================================
// Control register fields
`define ASB_CTRL_ALTERNATE_INPUT_SEL    0
`define ASB_CTRL_BUFFER_SPLIT_MODE    1
`define ASB_CTRL_ENABLE  2
`define ASB_CTRL_SAMPLES_PER_IRQ_LO 3
`define ASB_CTRL_SAMPLES_PER_IRQ_HI 6
`define ASB_CTRL_FILL_HALF_STATUS    7
`define ASB_CTRL_SCAN    10

// Mux register fields
`define ASB_MUX_APOS_LO  16
`define ASB_MUX_APOS_HI  19
`define ASB_MUX_ANEG     23
`define ASB_MUX_BPOS_LO  24
`define ASB_MUX_BPOS_HI  27
`define ASB_MUX_BNEG     31

// Status bits
`define ASB_ST_SEQ       0
`define ASB_ST_SAMPLE    1

// Buffer geometry
`define ASB_HALF_BASE    4'h8
`define ASB_SLOT_ZERO    4'h0

`endif

// *** shared/asb_pkg.sv ***
package asb_pkg;

    typedef enum logic [1:0] {
        ASB_IDLE = 2'b00,
        ASB_REQ  = 2'b01,
        ASB_WAIT = 2'b11
    } asb_state_t;

    // Request to the sample-and-hold and converter core
    typedef struct packed {
        logic       start;
        logic [3:0] pos_ch;
        logic       neg_is_ref;
        logic [3:0] neg_ch;
    } asb_conv_req_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } asb_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } asb_apb_rsp_t;

endpackage
